// ===== logic/dcsc_pkg.sv
// Package of constants and carrier types for the DMA channel status block.
package dcsc_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int NUM_CH    = 2;
	localparam int EV_PER_CH = 3;
	localparam int IRQ_W     = NUM_CH * EV_PER_CH;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] REG_STATUS     = 8'h00;
	localparam logic [7:0] REG_CUR        = 8'h04;
	localparam logic [7:0] REG_BASE       = 8'h08;
	localparam logic [7:0] REG_MODE_HI    = 8'h0C;
	localparam logic [7:0] REG_PATTERN    = 8'h10;
	localparam logic [7:0] REG_MASK       = 8'h14;
	localparam logic [7:0] REG_OPTION     = 8'h18;
	localparam logic [7:0] REG_CMD        = 8'h1C;
	localparam logic [7:0] REG_IRQ_STATUS = 8'h40;
	localparam logic [7:0] REG_IRQ_MASK   = 8'h44;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int ST_BUS_WAIT = 10;
	localparam int ST_SIP      = 9;
	localparam int ST_INHIBIT  = 6;
	localparam int ST_HW_REQ   = 5;
	localparam int ST_UPPER    = 4;
	localparam int ST_LOWER    = 3;
	localparam int ST_MATCH    = 2;
	localparam int ST_EOP      = 1;
	localparam int ST_TC       = 0;
	localparam int MH_SR       = 4;
	localparam int MH_HM       = 3;
	localparam int CMD_RELOAD  = 0;
	localparam int CMD_IACK    = 1;
	localparam int OPT_SEARCH  = 0;
	localparam int EV_TC       = 0;
	localparam int EV_EOP      = 1;
	localparam int EV_MC       = 2;

	// ****************************************
	// Match condition codes
	// ****************************************
	localparam logic [1:0] MC_WORD_MATCH = 2'h2;
	localparam logic [1:0] MC_BYTE_MATCH = 2'h3;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic {CS_IDLE, CS_RUN} dcsc_cs_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} dcsc_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} dcsc_apb_rsp_t;

	typedef struct packed {
		dcsc_cs_t    cs;
		logic        second_interrupt_waiting;
		logic        hm;
		logic        search;
		logic [1:0]  mcond;
		logic        tc;
		logic        eop;
		logic        mc;
		logic        upper_byte_match;
		logic        lower_byte_match;
		logic [15:0] cur;
		logic [15:0] base;
		logic [15:0] pat;
		logic [15:0] msk;
	} dcsc_chan_t;

	typedef struct packed {
		dcsc_chan_t [NUM_CH-1:0] ch;
		logic [NUM_CH-1:0]       hw_s1;
		logic [NUM_CH-1:0]       hw_s2;
		logic [NUM_CH-1:0]       hw_s3;
		logic [NUM_CH-1:0]       hw_f;
		logic [NUM_CH-1:0]       breq;
		logic                    eop_s1;
		logic                    eop_s2;
		logic                    eop_s3;
		logic                    eop_f;
		logic [IRQ_W-1:0]        irq_st;
		logic [IRQ_W-1:0]        irq_msk;
		logic                    irq;
		dcsc_apb_rsp_t           rsp;
	} dcsc_state_t;

	// ****************************************
	// Reset values
	// ****************************************
	localparam dcsc_state_t STATE_RST = '0;

endpackage : dcsc_pkg

// ===== logic/dcsc_top.sv
// Two-channel DMA status, match and operation count block with APB access.
//
// Operation
// - Status bit 10 is set while the channel requests the bus.
// - Second pending interrupt sets bit 9 and suspends channel until acknowledge.
// - Bit 6 shows the request inhibit; inhibited channel ignores hardware request.
// - Bit 5 reads one while the hardware request input is asserted.
// - Bit 4 sets when the masked upper byte matches the pattern.
// - Bit 3 sets when the masked lower byte matches the pattern.
// - Bit 1 sets when the end-of-process line terminates the operation.
// - The current count decrements by one for every datum moved.
// - An early stop keeps the remaining current count for later resumption.
// - After a completed transfer the current count holds zero.
// - A current count loaded as zero moves 64K data items.
// - The base count starts equal to the current count.
// - The base count never changes as transfers progress.
// - Software can copy the base count into the current count.
// - Bits 12 to 9 read zero while the channel is idle and no second interrupt waits.
// - The status register is read-only; writes have no effect.
`timescale 1ns/1ns

module dcsc_top
	import dcsc_pkg::*;
(
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst,
	// Register bus
	input  wire dcsc_apb_req_t     apb_req,
	output      dcsc_apb_rsp_t     apb_rsp,
	// Peripheral and bus side
	input  wire logic [NUM_CH-1:0] hw_req_pin,
	input  wire logic              end_of_process_pin,
	input  wire logic [NUM_CH-1:0] datum_done,
	input  wire logic [15:0]       datum,
	output      logic [NUM_CH-1:0] bus_request,
	// Interrupt
	output      logic              irq
);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic byte_eq(
		input logic [7:0] a,
		input logic [7:0] p,
		input logic [7:0] m
	);
		byte_eq = ((a ^ p) & ~m) == 8'h00;
	endfunction : byte_eq

	function automatic logic [15:0] status_word(
		input dcsc_chan_t c,
		input logic       hwr,
		input logic       bw
	);
		status_word              = 16'h0000;
		status_word[ST_BUS_WAIT] = bw;
		status_word[ST_SIP]      = c.second_interrupt_waiting;
		status_word[ST_INHIBIT]  = c.hm;
		status_word[ST_HW_REQ]   = hwr;
		status_word[ST_UPPER]    = c.upper_byte_match;
		status_word[ST_LOWER]    = c.lower_byte_match;
		status_word[ST_MATCH]    = c.mc;
		status_word[ST_EOP]      = c.eop;
		status_word[ST_TC]       = c.tc;
	endfunction : status_word

	// ****************************************
	// State
	// ****************************************
	dcsc_state_t q;
	dcsc_state_t d;

	logic        setup;
	logic        acc;
	logic        wr;
	logic        rd;
	logic        in_ch;
	logic        chs;
	logic [7:0]  roff;
	logic [15:0] st0;
	logic [15:0] st1;

	assign setup = apb_req.psel & ~apb_req.penable;
	assign acc   = apb_req.psel & apb_req.penable & q.rsp.pready;
	assign wr    = acc & apb_req.pwrite;
	assign rd    = acc & ~apb_req.pwrite;
	assign in_ch = (apb_req.paddr[7:6] == 2'h0);
	assign chs   = apb_req.paddr[5];
	assign roff  = {3'h0, apb_req.paddr[4:0]};
	assign st0   = status_word(q.ch[0], q.hw_f[0], q.breq[0]);
	assign st1   = status_word(q.ch[1], q.hw_f[1], q.breq[1]);

	assign apb_rsp     = q.rsp;
	assign bus_request = q.breq;
	assign irq         = q.irq;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic [IRQ_W-1:0]  ev;
		logic [NUM_CH-1:0] wsel;
		logic [NUM_CH-1:0] start;
		logic [NUM_CH-1:0] take;
		logic [NUM_CH-1:0] m_hi;
		logic [NUM_CH-1:0] m_lo;
		logic [NUM_CH-1:0] stop_m;
		ev     = '0;
		wsel   = '0;
		start  = '0;
		take   = '0;
		m_hi   = '0;
		m_lo   = '0;
		stop_m = '0;
		d      = q;

		// Pins pass three stages; a change counts once stages agree.
		d.hw_s1  = hw_req_pin;
		d.hw_s2  = q.hw_s1;
		d.hw_s3  = q.hw_s2;
		d.eop_s1 = end_of_process_pin;
		d.eop_s2 = q.eop_s1;
		d.eop_s3 = q.eop_s2;
		for (int i = 0; i < NUM_CH; i++) begin
			if (q.hw_s2[i] == q.hw_s3[i]) begin
				d.hw_f[i] = q.hw_s2[i];
			end
		end
		if (q.eop_s2 == q.eop_s3) begin
			d.eop_f = q.eop_s2;
		end

		// Zero wait states: the answer is prepared in the setup cycle.
		d.rsp.pready  = 1'b0;
		d.rsp.pslverr = 1'b0;
		if (setup) begin
			d.rsp.pready = 1'b1;
			d.rsp.prdata = 32'h0000_0000;
			if (in_ch && apb_req.paddr[1:0] == 2'h0) begin
				unique case (roff)
					REG_STATUS: d.rsp.prdata = 32'(status_word(
						q.ch[chs], q.hw_f[chs], q.breq[chs]));
					REG_CUR:     d.rsp.prdata = 32'(q.ch[chs].cur);
					REG_BASE:    d.rsp.prdata = 32'(q.ch[chs].base);
					REG_MODE_HI: d.rsp.prdata = 32'({q.ch[chs].hm,
						1'b0, q.ch[chs].mcond});
					REG_PATTERN: d.rsp.prdata = 32'(q.ch[chs].pat);
					REG_MASK:    d.rsp.prdata = 32'(q.ch[chs].msk);
					REG_OPTION:  d.rsp.prdata = 32'(q.ch[chs].search);
					REG_CMD:     d.rsp.prdata = 32'h0000_0000;
					default:     d.rsp.pslverr = 1'b1;
				endcase
			end else if (apb_req.paddr == REG_IRQ_STATUS) begin
				d.rsp.prdata = 32'(q.irq_st);
			end else if (apb_req.paddr == REG_IRQ_MASK) begin
				d.rsp.prdata = 32'(q.irq_msk);
			end else begin
				d.rsp.pslverr = 1'b1;
			end
		end

		for (int i = 0; i < NUM_CH; i++) begin
			wsel[i] = wr && in_ch && (chs == 1'(i));
			if (wsel[i]) begin
				unique case (roff)
					REG_CUR: begin
						d.ch[i].cur  = apb_req.pwdata[15:0];
						d.ch[i].base = apb_req.pwdata[15:0];
					end
					REG_BASE: begin
						d.ch[i].base = apb_req.pwdata[15:0];
					end
					REG_MODE_HI: begin
						d.ch[i].hm    = apb_req.pwdata[MH_HM];
						d.ch[i].mcond = apb_req.pwdata[1:0];
						start[i]      = apb_req.pwdata[MH_SR];
					end
					REG_PATTERN: d.ch[i].pat = apb_req.pwdata[15:0];
					REG_MASK:    d.ch[i].msk = apb_req.pwdata[15:0];
					REG_OPTION:  d.ch[i].search = apb_req.pwdata[OPT_SEARCH];
					REG_CMD: begin
						if (apb_req.pwdata[CMD_RELOAD]) begin
							d.ch[i].cur = q.ch[i].base;
						end
						if (apb_req.pwdata[CMD_IACK]) begin
							d.ch[i].second_interrupt_waiting = 1'b0;
						end
					end
					// Status writes land here and change nothing.
					default: d.ch[i].second_interrupt_waiting = d.ch[i].second_interrupt_waiting;
				endcase
			end

			// A masked channel only starts from software.
			if (q.hw_f[i] && !q.ch[i].hm) begin
				start[i] = 1'b1;
			end
			if (start[i] && q.ch[i].cs == CS_IDLE && !q.ch[i].second_interrupt_waiting) begin
				d.ch[i].cs  = CS_RUN;
				d.ch[i].tc  = 1'b0;
				d.ch[i].eop = 1'b0;
				d.ch[i].mc  = 1'b0;
				d.ch[i].upper_byte_match = 1'b0;
				d.ch[i].lower_byte_match = 1'b0;
			end

			// A suspended channel drops its request and takes no data.
			if (q.ch[i].cs == CS_RUN && !q.ch[i].second_interrupt_waiting) begin
				take[i] = datum_done[i] & q.breq[i];
				m_hi[i] = byte_eq(datum[15:8], q.ch[i].pat[15:8],
					q.ch[i].msk[15:8]);
				m_lo[i] = byte_eq(datum[7:0], q.ch[i].pat[7:0],
					q.ch[i].msk[7:0]);
				if (q.ch[i].mcond == MC_WORD_MATCH) begin
					stop_m[i] = m_hi[i] & m_lo[i];
				end else if (q.ch[i].mcond == MC_BYTE_MATCH) begin
					stop_m[i] = m_lo[i];
				end else begin
					stop_m[i] = ~(m_hi[i] & m_lo[i]);
				end
				if (take[i]) begin
					// Zero wraps to all ones, giving the full 64K run.
					d.ch[i].cur = q.ch[i].cur - 16'h0001;
					if (q.ch[i].search) begin
						d.ch[i].upper_byte_match = q.ch[i].upper_byte_match | m_hi[i];
						d.ch[i].lower_byte_match = q.ch[i].lower_byte_match | m_lo[i];
						ev[i*EV_PER_CH+EV_MC] = stop_m[i];
					end
					ev[i*EV_PER_CH+EV_TC] = (q.ch[i].cur == 16'h0001);
				end
				ev[i*EV_PER_CH+EV_EOP] = q.eop_f;
				// Ending the run leaves the count where it stopped.
				if (|ev[i*EV_PER_CH+:EV_PER_CH]) begin
					d.ch[i].cs  = CS_IDLE;
					d.ch[i].tc  = ev[i*EV_PER_CH+EV_TC];
					d.ch[i].eop = ev[i*EV_PER_CH+EV_EOP];
					d.ch[i].mc  = ev[i*EV_PER_CH+EV_MC];
					if (|q.irq_st[i*EV_PER_CH+:EV_PER_CH]) begin
						d.ch[i].second_interrupt_waiting = 1'b1;
					end
				end
			end
			d.breq[i] = (d.ch[i].cs == CS_RUN) && !d.ch[i].second_interrupt_waiting;
		end

		// Read clears the sticky bits; a new event still wins.
		if (rd && apb_req.paddr == REG_IRQ_STATUS) begin
			d.irq_st = '0;
		end
		if (wr && apb_req.paddr == REG_IRQ_MASK) begin
			d.irq_msk = apb_req.pwdata[IRQ_W-1:0];
		end
		d.irq_st = d.irq_st | ev;
		d.irq    = |(d.irq_st & d.irq_msk);

		if (rst) begin
			d = STATE_RST;
		end
	end

	always_ff @(posedge sys_clk) begin
		q <= d;
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	logic take0;
	logic wr0;
	assign take0 = q.ch[0].cs == CS_RUN && !q.ch[0].second_interrupt_waiting &&
		q.breq[0] && datum_done[0] && !apb_req.psel && !q.eop_f;
	assign wr0   = wr && in_ch && !chs;

	// Six checks skip cycles with bus traffic, since a register write
	// may legally move the same state in that cycle.
	a_bus_wait_bit: assert property (
		st0[ST_BUS_WAIT] == bus_request[0] &&
		(bus_request[0] -> q.ch[0].cs == CS_RUN))
		else $error("bus wait bit disagrees with request");
	a_sip_suspends: assert property (
		q.ch[0].second_interrupt_waiting |-> !bus_request[0])
		else $error("suspended channel still requests bus");
	a_inhibit_holds: assert property (
		q.ch[1].cs == CS_IDLE && q.ch[1].hm && !apb_req.psel
		|=> q.ch[1].cs == CS_IDLE)
		else $error("inhibited channel started");
	a_hw_req_seen: assert property (
		hw_req_pin[1] [*4] |=> st1[ST_HW_REQ])
		else $error("hardware request bit not set");
	a_count_step: assert property (
		take0 && q.ch[0].cur != 16'h0001
		|=> q.ch[0].cur == $past(q.ch[0].cur) - 16'h0001)
		else $error("count did not step by one");
	a_zero_wrap: assert property (
		take0 && q.ch[0].cur == 16'h0000 && !q.ch[0].search
		|=> q.ch[0].cur == 16'hFFFF && q.ch[0].cs == CS_RUN)
		else $error("zero count did not start a full run");
	a_base_load: assert property (
		wr0 && roff == REG_CUR && q.ch[0].cs == CS_IDLE
		|=> q.ch[0].base == q.ch[0].cur)
		else $error("base count not loaded with current count");
	a_base_steady: assert property (
		q.ch[0].cs == CS_RUN && !apb_req.psel
		|=> $stable(q.ch[0].base))
		else $error("base count moved");
	a_reload_copy: assert property (
		wr0 && roff == REG_CMD && apb_req.pwdata[CMD_RELOAD] &&
		q.ch[0].cs == CS_IDLE |=> q.ch[0].cur == $past(q.ch[0].base))
		else $error("base count not copied");
	a_count_end: assert property (
		take0 && q.ch[0].cur == 16'h0001
		|=> q.ch[0].cur == 16'h0000 && q.ch[0].tc &&
		q.ch[0].cs == CS_IDLE)
		else $error("terminal count not reported");
	a_eop_stop: assert property (
		q.ch[0].cs == CS_RUN && !q.ch[0].second_interrupt_waiting && q.eop_f &&
		!datum_done[0] && !apb_req.psel |=> q.ch[0].eop &&
		q.ch[0].cs == CS_IDLE && $stable(q.ch[0].cur))
		else $error("end of process stop wrong");
	a_idle_field: assert property (
		q.ch[0].cs == CS_IDLE && !q.ch[0].second_interrupt_waiting |-> st0[12:9] == 4'h0)
		else $error("idle field not zero");
	a_reserved_zero: assert property (
		st0[8:7] == 2'h0 && st1[8:7] == 2'h0)
		else $error("reserved status bits set");
	a_status_ro: assert property (
		wr0 && roff == REG_STATUS && q.ch[0].cs == CS_IDLE &&
		!q.hw_f[0] |=> $stable(q.ch[0]))
		else $error("status write changed the channel");
	a_ready_next: assert property (
		setup |=> apb_rsp.pready)
		else $error("no ready after setup");
	a_unmapped_err: assert property (
		setup && !in_ch && apb_req.paddr != REG_IRQ_STATUS &&
		apb_req.paddr != REG_IRQ_MASK |=> apb_rsp.pslverr)
		else $error("unmapped address not refused");
	a_irq_level: assert property (
		irq == |(q.irq_st & q.irq_msk))
		else $error("interrupt level wrong");

	c_count_done: cover property (q.ch[0].tc);
	c_eop_done: cover property (q.ch[0].eop);
	c_match_done: cover property (q.ch[0].mc);
	c_second_int: cover property (q.ch[0].second_interrupt_waiting);

endmodule : dcsc_top

// ===== testbench/dcsc_peer.sv
// Model of the requesting peripheral and the data bus.
`timescale 1ns/1ns

module dcsc_peer
	import dcsc_pkg::*;
(
	// Clock
	input  wire logic              sys_clk,
	// Towards the block
	output      logic [NUM_CH-1:0] hw_req_pin,
	output      logic              end_of_process_pin,
	output      logic [NUM_CH-1:0] datum_done,
	output      logic [15:0]       datum,
	input  wire logic [NUM_CH-1:0] bus_request
);
	initial begin
		hw_req_pin = '0;
		end_of_process_pin = 1'b0;
		datum_done = '0;
		datum = 16'hA5A5;
	end

	// One datum, offered once the channel holds the bus or after 50 cycles of waiting.
	// Idle data lines show the inverse, so stale data never looks fresh.
	task automatic send(input int ch, input logic [15:0] d);
		int n;
		n = 0;
		while (n < 50) begin
			@(negedge sys_clk);
			if (bus_request[ch] === 1'b1) break;
			n++;
		end
		@(posedge sys_clk);
		datum_done[ch] <= 1'b1;
		datum <= d;
		@(posedge sys_clk);
		datum_done[ch] <= 1'b0;
		datum <= ~d;
		@(posedge sys_clk);
	endtask : send

	// The pin is synchronised, so it is held well past the sync depth.
	task automatic stop();
		@(posedge sys_clk);
		end_of_process_pin <= 1'b1;
		repeat (6) @(posedge sys_clk);
		end_of_process_pin <= 1'b0;
		repeat (6) @(posedge sys_clk);
	endtask : stop

	task automatic hwreq(input int ch, input logic v);
		@(posedge sys_clk);
		hw_req_pin[ch] <= v;
	endtask : hwreq
endmodule : dcsc_peer

// ===== testbench/tb.sv
// Self-checking testbench of the DMA channel status block.
`timescale 1ns/1ns

module tb
	import dcsc_pkg::*;
;
	logic              sys_clk;
	logic              rst;
	dcsc_apb_req_t     req;
	dcsc_apb_rsp_t     rsp;
	logic [NUM_CH-1:0] hw;
	logic              eop;
	logic [NUM_CH-1:0] dd;
	logic [15:0]       dat;
	logic [NUM_CH-1:0] br;
	logic              irq;
	logic [31:0]       q;
	logic              e;
	int                num_errors = 0;
	int                checked = 0;

	dcsc_top dut_u (.sys_clk(sys_clk), .rst(rst), .apb_req(req),
		.apb_rsp(rsp), .hw_req_pin(hw), .end_of_process_pin(eop),
		.datum_done(dd), .datum(dat), .bus_request(br), .irq(irq));

	dcsc_peer peer_u (.sys_clk(sys_clk), .hw_req_pin(hw),
		.end_of_process_pin(eop), .datum_done(dd), .datum(dat),
		.bus_request(br));

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic test_done();
		if (num_errors == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : test_done

	task automatic cmp(input string nm, input logic [31:0] x,
		input logic [31:0] g);
		checked++;
		if (g !== x) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, x, g);
		end
	endtask : cmp

	// The request stands until pready is sampled high at a rising edge;
	// only the watchdog ends a wait that never gets an answer.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic er);
		@(posedge sys_clk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge sys_clk);
		req.penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (rsp.pready !== 1'b1);
		r = rsp.prdata;
		er = rsp.pslverr;
		req <= '0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, q, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] x,
		input string nm);
		apb(1'b0, a, 32'h0, q, e);
		cmp(nm, x, q);
	endtask : rd

	task automatic pin(input string nm, input logic [31:0] x);
		@(negedge sys_clk);
		cmp(nm, x, {29'h0, irq, br});
	endtask : pin

	task automatic srch(input logic [31:0] m, input logic [15:0] d,
		input logic [31:0] x);
		wr(REG_CUR, 32'h5);
		wr(REG_MODE_HI, m);
		peer_u.send(0, d);
		rd(REG_STATUS, x, "search status");
		rd(REG_IRQ_STATUS, 32'h4, "irq status match");
	endtask : srch

	initial begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		test_done();
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		rst = 1'b1;
		req = '0;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		rd(REG_STATUS, 32'h0, "status idle");
		wr(REG_STATUS, 32'h0000FFFF);
		rd(REG_STATUS, 32'h0, "status written");
		apb(1'b0, 8'h48, 32'h0, q, e);
		cmp("unmapped", 32'h1, {31'h0, e});
		apb(1'b0, 8'h02, 32'h0, q, e);
		cmp("unaligned", 32'h1, {31'h0, e});
		wr(REG_IRQ_MASK, 32'h3F);
		wr(REG_CUR, 32'h3);
		rd(REG_BASE, 32'h3, "base load");
		wr(REG_MODE_HI, 32'h10);
		pin("request raised", 32'h1);
		rd(REG_STATUS, 32'h400, "status running");
		repeat (3) peer_u.send(0, 16'h1234);
		rd(REG_CUR, 32'h0, "count end");
		rd(REG_BASE, 32'h3, "base kept");
		rd(REG_STATUS, 32'h1, "status count end");
		pin("irq raised", 32'h4);
		rd(REG_IRQ_STATUS, 32'h1, "irq status count");
		rd(REG_IRQ_STATUS, 32'h0, "irq status clear");
		pin("irq cleared", 32'h0);
		wr(REG_CMD, 32'h1);
		rd(REG_CUR, 32'h3, "count reload");
		wr(REG_MODE_HI, 32'h10);
		peer_u.send(0, 16'h5555);
		peer_u.stop();
		rd(REG_CUR, 32'h2, "count after stop");
		rd(REG_STATUS, 32'h2, "status stop");
		wr(REG_MODE_HI, 32'h10);
		peer_u.stop();
		rd(REG_STATUS, 32'h202, "status second pending");
		wr(REG_MODE_HI, 32'h10);
		pin("suspended", 32'h4);
		wr(REG_CMD, 32'h2);
		rd(REG_STATUS, 32'h2, "status acknowledged");
		rd(REG_IRQ_STATUS, 32'h2, "irq status stop");
		wr(REG_OPTION, 32'h1);
		wr(REG_PATTERN, 32'h12AB);
		wr(REG_MASK, 32'h0F00);
		srch(32'h13, 16'h99AB, 32'h0C);
		srch(32'h12, 16'h1FAB, 32'h1C);
		srch(32'h10, 16'h1234, 32'h14);
		rd(REG_PATTERN, 32'h12AB, "pattern readback");
		rd(REG_MASK, 32'h0F00, "mask readback");
		rd(REG_OPTION, 32'h1, "option readback");
		wr(REG_OPTION, 32'h0);
		wr(REG_CUR, 32'h0);
		wr(REG_MODE_HI, 32'h10);
		peer_u.send(0, 16'h0);
		rd(REG_CUR, 32'hFFFF, "count from zero");
		rd(REG_STATUS, 32'h400, "long run");
		peer_u.stop();
		rd(REG_IRQ_STATUS, 32'h2, "irq status stop");
		wr(8'h20 + REG_MODE_HI, 32'h8);
		rd(8'h20 + REG_MODE_HI, 32'h8, "mode readback");
		wr(8'h20 + REG_CUR, 32'h4);
		peer_u.hwreq(1, 1'b1);
		repeat (8) @(posedge sys_clk);
		rd(8'h20 + REG_STATUS, 32'h60, "inhibited request");
		pin("no start", 32'h0);
		wr(8'h20 + REG_MODE_HI, 32'h0);
		repeat (8) @(posedge sys_clk);
		rd(8'h20 + REG_STATUS, 32'h420, "hardware start");
		peer_u.hwreq(1, 1'b0);
		peer_u.stop();
		wr(REG_IRQ_MASK, 32'h0);
		pin("irq masked", 32'h0);
		wr(REG_IRQ_MASK, 32'h10);
		pin("irq unmasked", 32'h4);
		rd(REG_IRQ_STATUS, 32'h10, "irq status second channel");
		test_done();
	end
endmodule : tb
